//--- sms_marker_seq.sv
// sms_marker_seq.sv: marker command decoder, readback and sweep point sequencer
// assumes a sweep engine offering ascending points and a tick per dwell step
//
// How it works
// - selector, number, two-letter unit; value scaled
// - letters accepted in any case
// - selector zero turns all markers off
// - selector one to five activates that marker
// - marker-off terminator clears only selected marker
// - readback sends prefix, hertz digits, hertz terminator
// - each active marker inside the sweep span inserts one extra point
// - marker point precedes coinciding sweep point
// - at start frequency, start point comes first
// - marker point drives intensify and tone outputs
// - following same-frequency point has markers off
// - tone output is a five kilohertz square wave, toggling at ten kilohertz rate
// - frequency out of range raises code 01
// - marker number six to nine raises code 09
`timescale 1ns/10ps
`include "sms_defines.svh"

module sms_marker_seq #(
    parameter int TONE_HALF_CYC = `SMS_TONE_HALF_CYC
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic [7:0]                cmd_char,
    input  wire logic                      cmd_valid,
    output logic                           cmd_ready,
    output logic [7:0]                     resp_char,
    output logic                           resp_valid,
    input  wire logic                      resp_ready,
    input  wire logic                      msg_clear,
    output logic [7:0]                     msg_code,
    input  wire logic [`SMS_FREQ_W-1:0]    range_min_hz,
    input  wire logic [`SMS_FREQ_W-1:0]    range_max_hz,
    input  wire logic [`SMS_FREQ_W-1:0]    sweep_start_hz,
    input  wire logic [`SMS_FREQ_W-1:0]    sweep_stop_hz,
    input  wire logic                      pt_valid,
    input  wire logic [`SMS_FREQ_W-1:0]    pt_freq_hz,
    input  wire logic                      pt_first,
    output logic                           pt_ready,
    input  wire logic                      step_tick,
    output logic                           out_step,
    output logic [`SMS_FREQ_W-1:0]         out_freq_hz,
    output logic                           trace_intensify_out,
    output logic                           tone_marker_out,
    output logic [`SMS_NUM_MARKERS-1:0]    marker_active
);

    localparam int W = `SMS_FREQ_W;
    localparam int N = `SMS_NUM_MARKERS;

    function automatic logic [7:0] to_upper(input logic [7:0] c);
        to_upper = c;
        if (c >= `SMS_CH_LA && c <= `SMS_CH_LZ) begin
            to_upper = c - `SMS_CASE_OFS;
        end
    endfunction

    function automatic logic is_digit(input logic [7:0] c);
        is_digit = (c >= `SMS_CH_ZERO) && (c <= `SMS_CH_NINE);
    endfunction

    function automatic logic [W-1:0] pow10(input logic [3:0] e);
        case (e)
            4'h0:    pow10 = 40'h0000000001;
            4'h1:    pow10 = 40'h000000000A;
            4'h2:    pow10 = 40'h0000000064;
            4'h3:    pow10 = 40'h00000003E8;
            4'h4:    pow10 = 40'h0000002710;
            4'h5:    pow10 = 40'h00000186A0;
            4'h6:    pow10 = 40'h00000F4240;
            4'h7:    pow10 = 40'h0000989680;
            4'h8:    pow10 = 40'h0005F5E100;
            4'h9:    pow10 = 40'h003B9ACA00;
            4'hA:    pow10 = 40'h02540BE400;
            4'hB:    pow10 = 40'h174876E800;
            4'hC:    pow10 = 40'hE8D4A51000;
            default: pow10 = 40'h0000000000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // command decoder
    sms_pkg::sms_parse_t pst_ff;
    sms_pkg::sms_parse_t nxt_pst;
    logic [2:0]          sel_ff;
    logic [2:0]          nxt_sel;
    logic [W-1:0]        mant_ff;
    logic [W-1:0]        nxt_mant;
    logic [3:0]          frac_ff;
    logic [3:0]          nxt_frac;
    logic                dot_ff;
    logic                nxt_dot;
    logic                dig_ff;
    logic                nxt_dig;
    logic                movf_ff;
    logic                nxt_movf;
    logic [7:0]          first_ff;
    logic [7:0]          nxt_first;
    logic [W-1:0]        mfreq_ff [N];
    logic [W-1:0]        nxt_mfreq [N];
    logic [N-1:0]        mact_ff;
    logic [N-1:0]        nxt_mact;
    logic [7:0]          msg_ff;
    logic [7:0]          nxt_msg;
    logic                rb_go;
    logic [7:0]          ch;
    logic [3:0]          digit;
    logic [3:0]          unit_exp;
    logic                unit_hit;
    logic [2*W-1:0]      prod;
    logic                bad_freq;
    logic                rb_busy;

    assign ch        = to_upper(cmd_char);
    assign digit     = cmd_char[3:0];
    assign cmd_ready = !rb_busy;

    always_comb begin
        unit_hit = 1'b1;
        case ({first_ff, ch})
            {`SMS_CH_G, `SMS_CH_Z}: unit_exp = `SMS_EXP_GIGA;
            {`SMS_CH_M, `SMS_CH_Z}: unit_exp = `SMS_EXP_MEGA;
            {`SMS_CH_K, `SMS_CH_Z}: unit_exp = `SMS_EXP_KILO;
            {`SMS_CH_H, `SMS_CH_Z}: unit_exp = `SMS_EXP_HERTZ;
            default: begin
                unit_exp = `SMS_EXP_HERTZ;
                unit_hit = 1'b0;
            end
        endcase
    end

    assign prod     = {{W{1'b0}}, mant_ff} * {{W{1'b0}}, pow10(unit_exp - frac_ff)};
    assign bad_freq = (frac_ff > unit_exp) || movf_ff || (|prod[2*W-1:W]) || !dig_ff
                      || (prod[W-1:0] < range_min_hz) || (prod[W-1:0] > range_max_hz);

    always_comb begin
        nxt_pst   = pst_ff;
        nxt_sel   = sel_ff;
        nxt_mant  = mant_ff;
        nxt_frac  = frac_ff;
        nxt_dot   = dot_ff;
        nxt_dig   = dig_ff;
        nxt_movf  = movf_ff;
        nxt_first = first_ff;
        nxt_mfreq = mfreq_ff;
        nxt_mact  = mact_ff;
        nxt_msg   = msg_clear ? `SMS_MSG_NONE : msg_ff;
        rb_go     = 1'b0;
        if (cmd_valid && cmd_ready) begin
            case (pst_ff)
                sms_pkg::SMS_P_IDLE: begin
                    if (ch == `SMS_CH_M || ch == `SMS_CH_X) begin
                        nxt_pst = sms_pkg::SMS_P_SEL;
                    end
                end
                sms_pkg::SMS_P_SEL: begin
                    nxt_pst = sms_pkg::SMS_P_IDLE;
                    if (is_digit(ch)) begin
                        if (digit == 4'h0) begin
                            nxt_mact = '0;
                        end else if (digit <= 4'(N)) begin
                            nxt_sel  = 3'(digit - 4'h1);
                            nxt_mact[3'(digit - 4'h1)] = 1'b1;
                            nxt_mant = '0;
                            nxt_frac = '0;
                            nxt_dot  = 1'b0;
                            nxt_dig  = 1'b0;
                            nxt_movf = 1'b0;
                            nxt_pst  = sms_pkg::SMS_P_NUM;
                        end else begin
                            nxt_msg = `SMS_MSG_MARKER;
                        end
                    end
                end
                sms_pkg::SMS_P_NUM: begin
                    if (is_digit(ch)) begin
                        if (mant_ff >= `SMS_MANT_LIMIT) begin
                            nxt_movf = 1'b1;
                        end
                        nxt_mant = W'(mant_ff * 4'hA) + {{(W-4){1'b0}}, digit};
                        nxt_dig  = 1'b1;
                        if (dot_ff && frac_ff != 4'hF) begin
                            nxt_frac = frac_ff + 4'h1;
                        end
                    end else if (ch == `SMS_CH_DOT) begin
                        nxt_dot = 1'b1;
                    end else begin
                        nxt_first = ch;
                        nxt_pst   = sms_pkg::SMS_P_TERM;
                    end
                end
                sms_pkg::SMS_P_TERM: begin
                    nxt_pst = sms_pkg::SMS_P_IDLE;
                    if (unit_hit) begin
                        if (bad_freq) begin
                            nxt_msg = `SMS_MSG_RANGE;
                        end else begin
                            nxt_mfreq[sel_ff] = prod[W-1:0];
                            nxt_mact[sel_ff]  = 1'b1;
                        end
                    end else if (first_ff == `SMS_CH_M && ch == `SMS_CH_O) begin
                        nxt_mact[sel_ff] = 1'b0;
                    end else if (first_ff == `SMS_CH_O && ch == `SMS_CH_A) begin
                        rb_go = 1'b1;
                    end
                end
                default: nxt_pst = sms_pkg::SMS_P_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pst_ff   <= sms_pkg::SMS_P_IDLE;
            sel_ff   <= '0;
            mant_ff  <= '0;
            frac_ff  <= '0;
            dot_ff   <= 1'b0;
            dig_ff   <= 1'b0;
            movf_ff  <= 1'b0;
            first_ff <= '0;
            mfreq_ff <= '{default: '0};
            mact_ff  <= '0;
            msg_ff   <= `SMS_MSG_NONE;
        end else begin
            pst_ff   <= nxt_pst;
            sel_ff   <= nxt_sel;
            mant_ff  <= nxt_mant;
            frac_ff  <= nxt_frac;
            dot_ff   <= nxt_dot;
            dig_ff   <= nxt_dig;
            movf_ff  <= nxt_movf;
            first_ff <= nxt_first;
            mfreq_ff <= nxt_mfreq;
            mact_ff  <= nxt_mact;
            msg_ff   <= nxt_msg;
        end
    end

    assign msg_code      = msg_ff;
    assign marker_active = mact_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // readback string generator
    sms_pkg::sms_rb_t rst_ff;
    sms_pkg::sms_rb_t nxt_rst;
    logic [W-1:0]     rb_val_ff;
    logic [W-1:0]     nxt_rb_val;
    logic [3:0]       rb_pos_ff;
    logic [3:0]       nxt_rb_pos;
    logic [3:0]       rb_dig_ff;
    logic [3:0]       nxt_rb_dig;
    logic             rb_lead_ff;
    logic             nxt_rb_lead;
    logic             rb_idx_ff;
    logic             nxt_rb_idx;
    logic [7:0]       resp_char_ff;
    logic [7:0]       nxt_resp_char;
    logic             resp_valid_ff;
    logic             nxt_resp_valid;
    logic             can_load;

    assign rb_busy  = (rst_ff != sms_pkg::SMS_R_IDLE);
    assign can_load = !resp_valid_ff || resp_ready;

    always_comb begin
        nxt_rst        = rst_ff;
        nxt_rb_val     = rb_val_ff;
        nxt_rb_pos     = rb_pos_ff;
        nxt_rb_dig     = rb_dig_ff;
        nxt_rb_lead    = rb_lead_ff;
        nxt_rb_idx     = rb_idx_ff;
        nxt_resp_char  = resp_char_ff;
        nxt_resp_valid = resp_valid_ff && !resp_ready;
        case (rst_ff)
            sms_pkg::SMS_R_IDLE: begin
                if (rb_go) begin
                    nxt_rb_val  = mfreq_ff[sel_ff];
                    nxt_rb_pos  = `SMS_POS_TOP;
                    nxt_rb_dig  = '0;
                    nxt_rb_lead = 1'b0;
                    nxt_rb_idx  = 1'b0;
                    nxt_rst     = sms_pkg::SMS_R_PRE;
                end
            end
            sms_pkg::SMS_R_PRE: begin
                if (can_load) begin
                    nxt_resp_char  = rb_idx_ff ? `SMS_CH_K : `SMS_CH_M;
                    nxt_resp_valid = 1'b1;
                    nxt_rb_idx     = !rb_idx_ff;
                    if (rb_idx_ff) begin
                        nxt_rst = sms_pkg::SMS_R_DIG;
                    end
                end
            end
            sms_pkg::SMS_R_DIG: begin
                if (rb_val_ff >= pow10(rb_pos_ff)) begin
                    nxt_rb_val = rb_val_ff - pow10(rb_pos_ff);
                    nxt_rb_dig = rb_dig_ff + 4'h1;
                end else if (rb_dig_ff == 4'h0 && !rb_lead_ff && rb_pos_ff != 4'h0) begin
                    nxt_rb_pos = rb_pos_ff - 4'h1;
                end else if (can_load) begin
                    nxt_resp_char  = `SMS_CH_ZERO | {4'h0, rb_dig_ff};
                    nxt_resp_valid = 1'b1;
                    nxt_rb_lead    = 1'b1;
                    nxt_rb_dig     = '0;
                    if (rb_pos_ff == 4'h0) begin
                        nxt_rst = sms_pkg::SMS_R_SUF;
                    end else begin
                        nxt_rb_pos = rb_pos_ff - 4'h1;
                    end
                end
            end
            sms_pkg::SMS_R_SUF: begin
                if (can_load) begin
                    nxt_resp_char  = rb_idx_ff ? `SMS_CH_Z : `SMS_CH_H;
                    nxt_resp_valid = 1'b1;
                    nxt_rb_idx     = !rb_idx_ff;
                    if (rb_idx_ff) begin
                        nxt_rst = sms_pkg::SMS_R_IDLE;
                    end
                end
            end
            default: nxt_rst = sms_pkg::SMS_R_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_ff        <= sms_pkg::SMS_R_IDLE;
            rb_val_ff     <= '0;
            rb_pos_ff     <= '0;
            rb_dig_ff     <= '0;
            rb_lead_ff    <= 1'b0;
            rb_idx_ff     <= 1'b0;
            resp_char_ff  <= '0;
            resp_valid_ff <= 1'b0;
        end else begin
            rst_ff        <= nxt_rst;
            rb_val_ff     <= nxt_rb_val;
            rb_pos_ff     <= nxt_rb_pos;
            rb_dig_ff     <= nxt_rb_dig;
            rb_lead_ff    <= nxt_rb_lead;
            rb_idx_ff     <= nxt_rb_idx;
            resp_char_ff  <= nxt_resp_char;
            resp_valid_ff <= nxt_resp_valid;
        end
    end

    assign resp_char  = resp_char_ff;
    assign resp_valid = resp_valid_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // sweep point sequencer
    logic [N-1:0] done_ff;
    logic [N-1:0] nxt_done;
    logic         start_done_ff;
    logic         nxt_start_done;
    logic         out_step_ff;
    logic         nxt_out_step;
    logic [W-1:0] out_freq_ff;
    logic [W-1:0] nxt_out_freq;
    logic         out_mark_ff;
    logic         nxt_out_mark;
    logic [N-1:0] cand;
    logic [N-1:0] start_match;
    logic         found;
    logic [2:0]   best_idx;
    logic [W-1:0] best_freq;
    logic         in_span;

    always_comb begin
        cand        = '0;
        start_match = '0;
        found       = 1'b0;
        best_idx    = '0;
        best_freq   = '0;
        for (int i = 0; i < N; i++) begin
            in_span = (mfreq_ff[i] >= sweep_start_hz) && (mfreq_ff[i] <= sweep_stop_hz);
            start_match[i] = mact_ff[i] && in_span && (mfreq_ff[i] == pt_freq_hz);
            cand[i] = mact_ff[i] && in_span && !done_ff[i] &&
                      (pt_first ? (start_done_ff && mfreq_ff[i] == pt_freq_hz)
                                : (mfreq_ff[i] <= pt_freq_hz));
            if (cand[i] && (!found || mfreq_ff[i] < best_freq)) begin
                found     = 1'b1;
                best_idx  = 3'(i);
                best_freq = mfreq_ff[i];
            end
        end
    end

    always_comb begin
        nxt_done       = done_ff;
        nxt_start_done = start_done_ff;
        nxt_out_step   = 1'b0;
        nxt_out_freq   = out_freq_ff;
        nxt_out_mark   = out_mark_ff;
        pt_ready       = 1'b0;
        if (step_tick && pt_valid) begin
            if (pt_first && !start_done_ff) begin
                nxt_out_step = 1'b1;
                nxt_out_freq = pt_freq_hz;
                nxt_out_mark = 1'b0;
                nxt_done     = '0;
                if (|start_match) begin
                    nxt_start_done = 1'b1;
                end else begin
                    pt_ready = 1'b1;
                end
            end else if (found) begin
                nxt_out_step       = 1'b1;
                nxt_out_freq       = best_freq;
                nxt_out_mark       = 1'b1;
                nxt_done[best_idx] = 1'b1;
                if (pt_first && (cand & ~(N'(1) << best_idx)) == '0) begin
                    pt_ready       = 1'b1;
                    nxt_start_done = 1'b0;
                end
            end else begin
                pt_ready       = 1'b1;
                nxt_start_done = 1'b0;
                if (!pt_first) begin
                    nxt_out_step = 1'b1;
                    nxt_out_freq = pt_freq_hz;
                    nxt_out_mark = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            done_ff       <= '0;
            start_done_ff <= 1'b0;
            out_step_ff   <= 1'b0;
            out_freq_ff   <= '0;
            out_mark_ff   <= 1'b0;
        end else begin
            done_ff       <= nxt_done;
            start_done_ff <= nxt_start_done;
            out_step_ff   <= nxt_out_step;
            out_freq_ff   <= nxt_out_freq;
            out_mark_ff   <= nxt_out_mark;
        end
    end

    assign out_step            = out_step_ff;
    assign out_freq_hz         = out_freq_ff;
    assign trace_intensify_out = out_mark_ff;

    sms_tone_gen #(
        .HALF_CYC (TONE_HALF_CYC),
        .CNT_W    (16)
    ) u_tone (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .enable   (nxt_out_mark),
        .tone_out (tone_marker_out)
    );

endmodule

//--- sms_defines.svh
// sms_defines.svh: constants for the sweep marker sequencer
// assumes ASCII command characters and a 100 MHz system clock
`ifndef SMS_DEFINES_SVH
`define SMS_DEFINES_SVH

`define SMS_CLK_HZ          100000000
`define SMS_TONE_HZ         5000
`define SMS_TONE_HALF_CYC   (`SMS_CLK_HZ / (2 * `SMS_TONE_HZ))

`define SMS_FREQ_W          40
`define SMS_NUM_MARKERS     5
`define SMS_MANT_LIMIT      40'h1999999999

`define SMS_CH_M            8'h4D
`define SMS_CH_X            8'h58
`define SMS_CH_G            8'h47
`define SMS_CH_K            8'h4B
`define SMS_CH_H            8'h48
`define SMS_CH_Z            8'h5A
`define SMS_CH_O            8'h4F
`define SMS_CH_A            8'h41
`define SMS_CH_DOT          8'h2E
`define SMS_CH_ZERO         8'h30
`define SMS_CH_NINE         8'h39
`define SMS_CH_LA           8'h61
`define SMS_CH_LZ           8'h7A
`define SMS_CASE_OFS        8'h20

`define SMS_EXP_GIGA        4'h9
`define SMS_EXP_MEGA        4'h6
`define SMS_EXP_KILO        4'h3
`define SMS_EXP_HERTZ       4'h0
`define SMS_POS_TOP         4'hC

`define SMS_MSG_NONE        8'h00
`define SMS_MSG_RANGE       8'h01
`define SMS_MSG_MARKER      8'h09

`endif

//--- sms_pkg.sv
// sms_pkg.sv: state types of the sweep marker sequencer
// assumes nothing beyond a SystemVerilog compiler
package sms_pkg;

    typedef enum logic [3:0] {
        SMS_P_IDLE = 4'h1,
        SMS_P_SEL  = 4'h2,
        SMS_P_NUM  = 4'h4,
        SMS_P_TERM = 4'h8
    } sms_parse_t;

    typedef enum logic [3:0] {
        SMS_R_IDLE = 4'h1,
        SMS_R_PRE  = 4'h2,
        SMS_R_DIG  = 4'h4,
        SMS_R_SUF  = 4'h8
    } sms_rb_t;

endpackage

//--- sms_tone_gen.sv
// sms_tone_gen.sv: square wave tone divider for marker points
// assumes one system clock; enable low holds the tone low
`timescale 1ns/10ps
`include "sms_defines.svh"

module sms_tone_gen #(
    parameter int HALF_CYC = `SMS_TONE_HALF_CYC,
    parameter int CNT_W    = 16
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic enable,
    output logic      tone_out
);

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             tone_ff;
    logic             nxt_tone;

    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_tone = tone_ff;
        if (!enable) begin
            nxt_cnt  = '0;
            nxt_tone = 1'b0;
        end else if (cnt_ff == CNT_W'(HALF_CYC - 1)) begin
            nxt_cnt  = '0;
            nxt_tone = !tone_ff;
        end else begin
            nxt_cnt = cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff  <= '0;
            tone_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tone_ff <= nxt_tone;
        end
    end

    assign tone_out = tone_ff;

endmodule

//--- sms_marker_seq_asserts.sv
// sms_marker_seq_asserts.sv: port checker for the marker sequencer
// assumes one clock domain and a small tone half period in simulation
`timescale 1ns/10ps
`include "sms_defines.svh"

module sms_marker_seq_chk #(
    parameter int TONE_HALF_CYC = 4
) (
    input wire logic                   clk_sys,
    input wire logic                   rst_n,
    input wire logic                   cmd_ready,
    input wire logic [7:0]             resp_char,
    input wire logic                   resp_valid,
    input wire logic                   resp_ready,
    input wire logic [7:0]             msg_code,
    input wire logic [`SMS_FREQ_W-1:0] sweep_start_hz,
    input wire logic [`SMS_FREQ_W-1:0] sweep_stop_hz,
    input wire logic [`SMS_FREQ_W-1:0] pt_freq_hz,
    input wire logic                   pt_first,
    input wire logic                   pt_ready,
    input wire logic                   step_tick,
    input wire logic                   out_step,
    input wire logic [`SMS_FREQ_W-1:0] out_freq_hz,
    input wire logic                   trace_intensify_out,
    input wire logic                   tone_marker_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    logic        tone_ff;
    logic [15:0] run_ff;
    // length of the current tone level while marked
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tone_ff <= 1'b0;
            run_ff  <= 16'h0000;
        end else begin
            tone_ff <= tone_marker_out;
            run_ff  <= (tone_marker_out != tone_ff || !trace_intensify_out) ? 16'h0001
                                                                            : run_ff + 16'h0001;
        end
    end
    sequence mark_pt;
        out_step && trace_intensify_out;
    endsequence
    ////////////////////////////////////////////////////////////////
    tone_gate_a: assert property (!trace_intensify_out |-> !tone_marker_out)
        else $error("tone active outside a marker point");
    tone_rate_a: assert property (run_ff <= TONE_HALF_CYC + 1)
        else $error("tone level held too long");
    step_cause_a: assert property (out_step |-> $past(step_tick))
        else $error("point emitted without a tick");
    plain_after_a: assert property (pt_ready && !pt_first |=> out_step
        && !trace_intensify_out && out_freq_hz == $past(pt_freq_hz))
        else $error("consumed point not emitted unmarked");
    span_only_a: assert property (mark_pt |-> out_freq_hz >= sweep_start_hz
        && out_freq_hz <= sweep_stop_hz)
        else $error("marker point outside span");
    msg_legal_a: assert property (msg_code inside {8'h00, 8'h01, 8'h09})
        else $error("illegal message code");
    resp_hold_a: assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp_char))
        else $error("readback char dropped");
    resp_excl_a: assert property (resp_valid && resp_char != `SMS_CH_Z |-> !cmd_ready)
        else $error("commands taken during readback");
endmodule

bind sms_marker_seq sms_marker_seq_chk #(.TONE_HALF_CYC(TONE_HALF_CYC)) u_chk (.*);

//--- sms_host_model.sv
// sms_host_model.sv: remote controller sending command strings, slow reader
// assumes send is entered shortly after a rising edge
`timescale 1ns/10ps

module sms_host_model (
    input  wire logic clk_sys,
    output logic      [7:0] cmd_char,
    output logic      cmd_valid,
    input  wire logic cmd_ready,
    input  wire logic [7:0] resp_char,
    input  wire logic resp_valid,
    output logic      resp_ready
);
    logic [7:0] rx[$];
    initial begin
        cmd_char   = 8'h00;
        cmd_valid  = 1'b0;
        resp_ready = 1'b0;
    end
    // accepts only every other cycle
    always @(posedge clk_sys) resp_ready <= #1 ~resp_ready;
    always @(posedge clk_sys) if (resp_valid && resp_ready) rx.push_back(resp_char);

    task send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            cmd_char  = s[i];
            cmd_valid = 1'b1;
            forever begin
                @(negedge clk_sys);
                if (cmd_ready) break;
            end
            @(posedge clk_sys);
            #1;
        end
        cmd_valid = 1'b0;
        cmd_char  = ~cmd_char;
    endtask
endmodule

//--- sweep_marker_sequencer_tb.sv
// sweep_marker_sequencer_tb.sv: directed scenarios for the marker sequencer
// assumes the host model and the bound checker
`timescale 1ns/10ps
`include "sms_defines.svh"

module sweep_marker_sequencer_tb;
    logic clk_sys, rst_n, cmd_valid, cmd_ready, resp_valid, resp_ready, msg_clear, pt_valid;
    logic pt_first, pt_ready, step_tick, out_step, trace_intensify_out, tone_marker_out;
    logic [7:0] cmd_char, resp_char, msg_code;
    logic [4:0] marker_active;
    logic [`SMS_FREQ_W-1:0] range_min_hz, range_max_hz, sweep_start_hz, sweep_stop_hz;
    logic [`SMS_FREQ_W-1:0] pt_freq_hz, out_freq_hz;
    int fail_count, comparisons, cycles;

    sms_marker_seq #(.TONE_HALF_CYC(4)) uut (.*);
    sms_host_model host (.*);
    ////////////////////////////////////////////////////////////////
    task finish_test;
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %0h wanted %0h", $time, what, got, exp);
        end
    endtask
    task cmd(input string s);
        host.send(s);
        @(posedge clk_sys);
        #1;
    endtask
    task tick(input logic [39:0] f, input logic m, input int n);
        step_tick = 1'b1;
        @(posedge clk_sys);
        #1 step_tick = 1'b0;
        chk(out_step, 1, "step");
        chk(out_freq_hz, f, "freq");
        chk(trace_intensify_out, m, "mark");
        if (!m) chk(tone_marker_out, 0, "tone");
        repeat (n + 1) @(posedge clk_sys) #1;
    endtask
    ////////////////////////////////////////////////////////////////
    task t_set;
        cmd("m312.34Gz");
        chk(marker_active, 5'h04, "set");
        chk(msg_code, 8'h00, "msg");
    endtask
    task t_read;
        string e;
        e = "MK500HZ";
        cmd("M5500HZ");
        host.rx.delete();
        cmd("X5oa");
        for (int k = 0; k < 600 && host.rx.size() < 7; k++) @(posedge clk_sys);
        for (int k = 0; k < 7; k++) chk(host.rx[k], e[k], "readback");
        #1;
    endtask
    task t_off;
        cmd("M3MO");
        chk(marker_active, 5'h10, "off");
    endtask
    task t_err;
        cmd("M7");
        chk(msg_code, 8'h09, "bad marker");
        chk(marker_active, 5'h10, "kept");
        msg_clear = 1'b1;
        @(posedge clk_sys);
        #1 msg_clear = 1'b0;
        chk(msg_code, 8'h00, "cleared");
        cmd("M299GZ");
        chk(msg_code, 8'h01, "range");
    endtask
    task t_sweep;
        cmd("M0");
        chk(marker_active, 5'h00, "all off");
        cmd("M17000HZ");
        cmd("M27KZ");
        cmd("M31KZ");
        pt_valid = 1'b1;
        pt_first = 1'b1;
        pt_freq_hz = 40'h3E8;
        tick(40'h3E8, 1'b0, 0);
        tick(40'h3E8, 1'b1, 12);
        pt_first = 1'b0;
        pt_freq_hz = 40'h1B58;
        tick(40'h1B58, 1'b1, 0);
        tick(40'h1B58, 1'b1, 12);
        tick(40'h1B58, 1'b0, 0);
        pt_valid = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            finish_test;
        end
    end
    initial begin
        rst_n = 1'b0;
        msg_clear = 1'b0;
        step_tick = 1'b0;
        pt_valid = 1'b0;
        pt_first = 1'b0;
        pt_freq_hz = 40'h0;
        range_min_hz = 40'h64;
        range_max_hz = 40'h4A817C800;
        sweep_start_hz = 40'h3E8;
        sweep_stop_hz = 40'h2328;
        repeat (3) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        t_set;
        t_read;
        t_off;
        t_err;
        t_sweep;
        finish_test;
    end
endmodule
